// File: design/dbmrs_pkg.sv
// Purpose : Shared constants and types for the DMA bus-mode and request-sampling block
// Assumes : Single clock, plain register port, 8-bit byte addresses
// Notes   : Channel control word layout is carried by dbmrs_ctrl_s

package dbmrs_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int          DBMRS_NCH      = 4;
  localparam int          DBMRS_NEXT     = 2;
  localparam int          DBMRS_COUNT_W  = 16;
  localparam int          DBMRS_AW       = 8;
  localparam int          DBMRS_DW       = 32;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  DBMRS_CTRL_OFF   = 8'h00;
  localparam logic [7:0]  DBMRS_COUNT_OFF  = 8'h04;
  localparam logic [7:0]  DBMRS_CH_STRIDE  = 8'h08;
  localparam logic [7:0]  DBMRS_WAIT_OFF   = 8'h40;
  localparam logic [7:0]  DBMRS_STATUS_OFF = 8'h44;

  // Wait control word fields
  localparam int          DBMRS_DUALW_LSB  = 0;
  localparam int          DBMRS_SINGW_LSB  = 4;
  localparam int          DBMRS_DRAMLP_BIT = 8;
  localparam int          DBMRS_WAIT_W     = 4;

  // Control word bit position of the software-cleared done flag, and the control word width
  localparam int          DBMRS_DONE_BIT   = 12;
  localparam int          DBMRS_CTRL_W     = 14;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  DBMRS_REQ_AUTO   = 2'h0;
  localparam logic [1:0]  DBMRS_REQ_EXT    = 2'h1;
  localparam logic [1:0]  DBMRS_REQ_PERIPH = 2'h2;
  localparam logic [1:0]  DBMRS_PID_OTHER  = 2'h0;
  localparam logic [1:0]  DBMRS_PID_SERIAL = 2'h1;
  localparam logic [1:0]  DBMRS_PID_CONV   = 2'h2;

  // ----------------------------------------------------------------
  // Timing, in states of the 40 ns clock
  // ----------------------------------------------------------------
  localparam logic [1:0]  DBMRS_REQ_LAT      = 2'h2;
  localparam logic [5:0]  DBMRS_SINGLE_BASE  = 6'h01;
  localparam logic [5:0]  DBMRS_DUAL_BASE    = 6'h01;
  localparam logic [5:0]  DBMRS_CS_SMP_ST    = 6'h02;
  localparam logic [5:0]  DBMRS_DRAM_SMP_ST  = 6'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DBMRS_IDLE = 2'b00,
    DBMRS_REQ  = 2'b01,
    DBMRS_XFER = 2'b10
  } dbmrs_fsm_e;

  typedef enum logic [1:0] {
    DBMRS_SMP_EVERY = 2'b00,
    DBMRS_SMP_BLOCK = 2'b01,
    DBMRS_SMP_ACK   = 2'b10
  } dbmrs_smp_e;

  typedef struct packed {
    logic       cfg_err;
    logic       done;
    logic       reg16;
    logic       ep_periph;
    logic       ep_reqmod;
    logic       edge_det;
    logic       unit16;
    logic       single_addr;
    logic [1:0] periph_id;
    logic [1:0] req_src;
    logic       bus_mode_select;
    logic       channel_enable_bit;
  } dbmrs_ctrl_s;

  typedef struct packed {
    dbmrs_ctrl_s [DBMRS_NCH-1:0]                    ctrl;
    logic        [DBMRS_NCH-1:0][DBMRS_COUNT_W-1:0] count;
    logic        [DBMRS_WAIT_W-1:0]                 dual_wait;
    logic        [DBMRS_WAIT_W-1:0]                 single_wait;
    logic                                           dram_lp;
    logic        [DBMRS_NCH-1:0]                    pending;
    logic        [DBMRS_NCH-1:0][1:0]               age;
    dbmrs_smp_e  [DBMRS_NEXT-1:0]                   smp;
    logic        [DBMRS_NEXT-1:0]                   edge_seen;
    logic        [DBMRS_NEXT-1:0]                   pin_prev;
    dbmrs_fsm_e                                     fsm;
    logic        [1:0]                              cur;
    logic        [5:0]                              scnt;
    logic                                           alt;
    logic                                           bus_req;
    logic        [DBMRS_NEXT-1:0]                   ack;
    logic        [DBMRS_DW-1:0]                     rd_data;
  } dbmrs_state_s;

endpackage : dbmrs_pkg

// File: design/dbmrs_top.sv
// Purpose : Bus ownership, channel pre-emption and request-pin sampling for a 4-channel DMA
// Assumes : Inputs synchronous to clock; bus arbiter answers bus_req with bus_grant
// Notes   : Fixed priority, channel 0 highest; request pins are active low
//
// Overview of operation
// - Cycle-steal channels release the bus after every single transfer unit unless a burst channel is ready.
// - Cycle-steal mode is legal for every source, destination and request category.
// - A burst channel keeps the bus and transfers back to back until it ends.
// - Level-detected external burst releases the bus after the unit once pin goes high.
// - A burst channel cannot take its requests from the serial interface.
// - Single-address transfers take only external requests, on channels 0 and 1.
// - External pin requests are accepted only by channels 0 and 1.
// - Dual transfers without peripheral endpoint refuse serial or converter request sources.
// - Serial or converter requests need that module as source or destination.
// - Unit size must match the peripheral register's permitted access size.
// - A higher-priority request pre-empts a burst channel at the next unit boundary.
// - A pre-empting burst channel finishes entirely before the lower one resumes.
// - A cycle-steal pre-emptor alternates unit by unit with the burst channel.
// - During that alternation the bus is never handed back to the CPU.
// - Unit length follows dual wait setting for dual, single wait for single.
// - A transfer starts no earlier than two states after request detection.
// - Edge detection needs a fresh falling edge before another request is taken.
// - Cycle steal: after a detection, sampling pauses until the acknowledged unit.
// - That sample falls on the third state of the acknowledged unit.
// - No request there: sample at next acknowledged state, then every state.
// - DRAM long-pitch single transfers sample in the unit's second state.
// - Each channel's control register selects burst or cycle-steal bus mode.
// - A channel ends when its count reaches zero or software clears enable.
//
// Our own choices: strobed register access and the address map.

module dbmrs_top
  import dbmrs_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic [DBMRS_AW-1:0]   reg_addr,
  input  wire logic [DBMRS_DW-1:0]   reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [DBMRS_DW-1:0]   reg_rdata,
  input  wire logic [DBMRS_NEXT-1:0] transfer_request_pin_n,
  input  wire logic [DBMRS_NCH-1:0]  periph_req,
  input  wire logic                  bus_grant,
  output logic                       bus_req,
  output logic      [DBMRS_NEXT-1:0] transfer_ack_pin,
  output logic                       xfer_busy,
  output logic      [1:0]            xfer_chan
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] dbmrs_pick(input logic [DBMRS_NCH-1:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = DBMRS_NCH - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : dbmrs_pick

  // Illegal setups are refused at write time so they can never start
  function automatic logic dbmrs_cfg_ok(input logic [1:0] ch, input dbmrs_ctrl_s c);
    logic ok;
    ok = 1'b1;
    if (c.bus_mode_select && c.req_src == DBMRS_REQ_PERIPH
        && c.periph_id == DBMRS_PID_SERIAL) begin
      ok = 1'b0;
    end
    if (c.req_src == DBMRS_REQ_EXT && ch > 2'h1) begin
      ok = 1'b0;
    end
    if (c.single_addr && (c.req_src != DBMRS_REQ_EXT || c.ep_periph)) begin
      ok = 1'b0;
    end
    if (c.req_src == DBMRS_REQ_PERIPH && c.periph_id != DBMRS_PID_OTHER
        && !(c.ep_periph && c.ep_reqmod)) begin
      ok = 1'b0;
    end
    if (c.ep_periph && (c.unit16 != c.reg16)) begin
      ok = 1'b0;
    end
    if (c.req_src == 2'h3 || c.periph_id == 2'h3) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : dbmrs_cfg_ok

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dbmrs_state_s              st_reg;
  dbmrs_state_s              st_next;
  logic [5:0]                ulen;
  logic [5:0]                smp_pt;
  logic                      unit_end;
  logic                      last_unit;
  logic [DBMRS_NCH-1:0]      ready;
  logic [DBMRS_NCH-1:0]      burst_rdy;
  logic [1:0]                sel;
  logic [DBMRS_NEXT-1:0]     fall;
  logic [DBMRS_NEXT-1:0]     det;
  logic                      own;
  dbmrs_ctrl_s               wctrl;

  always_comb begin
    st_next   = st_reg;
    st_next.rd_data = '0;
    ulen      = '0;
    smp_pt    = '0;
    unit_end  = 1'b0;
    last_unit = 1'b0;
    ready     = '0;
    burst_rdy = '0;
    sel       = 2'h0;
    fall      = '0;
    det       = '0;
    own       = 1'b0;
    wctrl     = '0;

    // ----------------------------------------------------------------
    // Unit length and sample point
    // ----------------------------------------------------------------
    if (st_reg.ctrl[st_reg.cur].single_addr) begin
      ulen = DBMRS_SINGLE_BASE + 6'(st_reg.single_wait);
    end else begin
      ulen = 6'(2 * (DBMRS_DUAL_BASE + 6'(st_reg.dual_wait)));
    end
    if (st_reg.dram_lp && st_reg.ctrl[st_reg.cur].single_addr) begin
      smp_pt = DBMRS_DRAM_SMP_ST;
    end else begin
      smp_pt = DBMRS_CS_SMP_ST;
    end
    // Short units take their sample in their last state
    if (smp_pt > ulen - 6'h01) begin
      smp_pt = ulen - 6'h01;
    end
    unit_end  = (st_reg.fsm == DBMRS_XFER) && (st_reg.scnt == ulen - 6'h01);
    last_unit = unit_end && (st_reg.count[st_reg.cur] == DBMRS_COUNT_W'(1));

    // ----------------------------------------------------------------
    // External pin sampling
    // ----------------------------------------------------------------
    for (int i = 0; i < DBMRS_NEXT; i++) begin
      fall[i] = st_reg.pin_prev[i] & ~transfer_request_pin_n[i];
      st_next.pin_prev[i] = transfer_request_pin_n[i];
      // Edge latch keeps a falling edge seen while sampling is paused
      det[i] = st_reg.ctrl[i].edge_det ? (st_reg.edge_seen[i] | fall[i])
                                       : ~transfer_request_pin_n[i];
      if (fall[i]) begin
        st_next.edge_seen[i] = 1'b1;
      end
      own = (st_reg.fsm == DBMRS_XFER) && (st_reg.cur == 2'(i));
      if (st_reg.ctrl[i].channel_enable_bit && st_reg.ctrl[i].req_src == DBMRS_REQ_EXT) begin
        if (st_reg.ctrl[i].bus_mode_select) begin
          if (!st_reg.pending[i]) begin
            if (det[i]) begin
              st_next.pending[i]   = 1'b1;
              st_next.edge_seen[i] = 1'b0;
              st_next.age[i]       = 2'h0;
            end
          end else if (!st_reg.ctrl[i].edge_det && own && unit_end
                       && transfer_request_pin_n[i]) begin
            st_next.pending[i] = 1'b0;
          end
        end else begin
          case (st_reg.smp[i])
            DBMRS_SMP_EVERY: begin
              if (det[i]) begin
                st_next.pending[i]   = 1'b1;
                st_next.edge_seen[i] = 1'b0;
                st_next.age[i]       = 2'h0;
                st_next.smp[i]       = DBMRS_SMP_BLOCK;
              end
            end
            DBMRS_SMP_BLOCK: begin
              if (own && st_reg.scnt == smp_pt) begin
                if (det[i]) begin
                  st_next.pending[i]   = 1'b1;
                  st_next.edge_seen[i] = 1'b0;
                  st_next.age[i]       = 2'h0;
                end else begin
                  st_next.smp[i] = DBMRS_SMP_ACK;
                end
              end
            end
            DBMRS_SMP_ACK: begin
              if (own && det[i]) begin
                st_next.pending[i]   = 1'b1;
                st_next.edge_seen[i] = 1'b0;
                st_next.age[i]       = 2'h0;
                st_next.smp[i]       = DBMRS_SMP_BLOCK;
              end else begin
                st_next.smp[i] = DBMRS_SMP_EVERY;
              end
            end
            default: begin
              st_next.smp[i] = DBMRS_SMP_EVERY;
            end
          endcase
        end
      end else begin
        st_next.smp[i] = DBMRS_SMP_EVERY;
      end
    end

    // ----------------------------------------------------------------
    // Readiness per channel
    // ----------------------------------------------------------------
    for (int i = 0; i < DBMRS_NCH; i++) begin
      if (st_reg.age[i] != 2'h3) begin
        st_next.age[i] = st_reg.age[i] + 2'h1;
      end
      case (st_reg.ctrl[i].req_src)
        DBMRS_REQ_AUTO:   ready[i] = 1'b1;
        DBMRS_REQ_EXT:    ready[i] = st_reg.pending[i] && st_reg.age[i] >= DBMRS_REQ_LAT;
        DBMRS_REQ_PERIPH: ready[i] = st_reg.pending[i];
        default:          ready[i] = 1'b0;
      endcase
      ready[i] = ready[i] && st_reg.ctrl[i].channel_enable_bit;
      // Channel whose unit now ends without a further request drops out
      if (unit_end && st_reg.cur == 2'(i)
          && (last_unit || !st_next.pending[i] && st_reg.ctrl[i].req_src != DBMRS_REQ_AUTO)) begin
        ready[i] = 1'b0;
      end
      burst_rdy[i] = ready[i] && st_reg.ctrl[i].bus_mode_select;
    end

    // Alternation hands the next unit back to the burst channel
    if (st_reg.alt && burst_rdy != '0) begin
      sel = dbmrs_pick(burst_rdy);
    end else begin
      sel = dbmrs_pick(ready);
    end

    // ----------------------------------------------------------------
    // Bus ownership
    // ----------------------------------------------------------------
    case (st_reg.fsm)
      DBMRS_IDLE: begin
        if (ready != '0) begin
          st_next.fsm     = DBMRS_REQ;
          st_next.bus_req = 1'b1;
        end
      end
      DBMRS_REQ: begin
        if (ready == '0) begin
          st_next.fsm     = DBMRS_IDLE;
          st_next.bus_req = 1'b0;
        end else if (bus_grant) begin
          st_next.fsm  = DBMRS_XFER;
          st_next.cur  = sel;
          st_next.scnt = '0;
          st_next.alt  = 1'b0;
          if (!st_reg.ctrl[sel].bus_mode_select) begin
            st_next.pending[sel] = 1'b0;
          end
        end
      end
      DBMRS_XFER: begin
        st_next.scnt = st_reg.scnt + 6'h01;
        if (unit_end) begin
          st_next.count[st_reg.cur] = st_reg.count[st_reg.cur] - DBMRS_COUNT_W'(1);
          if (last_unit) begin
            st_next.ctrl[st_reg.cur].channel_enable_bit = 1'b0;
            st_next.ctrl[st_reg.cur].done               = 1'b1;
            st_next.pending[st_reg.cur]                 = 1'b0;
          end
          if (burst_rdy != '0 && ready != '0) begin
            // A live burst channel keeps the bus between units
            st_next.scnt = '0;
            st_next.cur  = sel;
            st_next.alt  = !st_reg.ctrl[sel].bus_mode_select;
            if (!st_reg.ctrl[sel].bus_mode_select) begin
              st_next.pending[sel] = 1'b0;
            end
          end else begin
            st_next.fsm     = DBMRS_IDLE;
            st_next.bus_req = 1'b0;
            st_next.alt     = 1'b0;
          end
        end
      end
      default: begin
        st_next.fsm     = DBMRS_IDLE;
        st_next.bus_req = 1'b0;
      end
    endcase
    // Latched after the unit-start clear, so a request in that cycle is kept
    for (int i = 0; i < DBMRS_NCH; i++) begin
      if (st_reg.ctrl[i].req_src == DBMRS_REQ_PERIPH && periph_req[i]
          && st_next.ctrl[i].channel_enable_bit) begin
        st_next.pending[i] = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    for (int i = 0; i < DBMRS_NCH; i++) begin
      if (reg_wr && reg_addr == DBMRS_CTRL_OFF + 8'(i) * DBMRS_CH_STRIDE) begin
        wctrl         = dbmrs_ctrl_s'(reg_wdata[DBMRS_CTRL_W-1:0]);
        wctrl.done    = st_next.ctrl[i].done & ~reg_wdata[DBMRS_DONE_BIT];
        wctrl.cfg_err = !dbmrs_cfg_ok(2'(i), wctrl);
        if (wctrl.cfg_err) begin
          wctrl.channel_enable_bit = 1'b0;
        end
        // A completion landing in the clear cycle is kept
        if (last_unit && st_reg.cur == 2'(i)) begin
          wctrl.done               = 1'b1;
          wctrl.channel_enable_bit = 1'b0;
        end
        st_next.ctrl[i] = wctrl;
        if (!wctrl.channel_enable_bit) begin
          st_next.pending[i] = 1'b0;
        end
      end
      if (reg_wr && reg_addr == DBMRS_COUNT_OFF + 8'(i) * DBMRS_CH_STRIDE) begin
        st_next.count[i] = reg_wdata[DBMRS_COUNT_W-1:0];
      end
      if (reg_rd && reg_addr == DBMRS_CTRL_OFF + 8'(i) * DBMRS_CH_STRIDE) begin
        st_next.rd_data = DBMRS_DW'(st_reg.ctrl[i]);
      end
      if (reg_rd && reg_addr == DBMRS_COUNT_OFF + 8'(i) * DBMRS_CH_STRIDE) begin
        st_next.rd_data = DBMRS_DW'(st_reg.count[i]);
      end
    end
    if (reg_wr && reg_addr == DBMRS_WAIT_OFF) begin
      st_next.dual_wait   = reg_wdata[DBMRS_DUALW_LSB +: DBMRS_WAIT_W];
      st_next.single_wait = reg_wdata[DBMRS_SINGW_LSB +: DBMRS_WAIT_W];
      st_next.dram_lp     = reg_wdata[DBMRS_DRAMLP_BIT];
    end
    if (reg_rd && reg_addr == DBMRS_WAIT_OFF) begin
      st_next.rd_data = DBMRS_DW'({st_reg.dram_lp, st_reg.single_wait, st_reg.dual_wait});
    end
    if (reg_rd && reg_addr == DBMRS_STATUS_OFF) begin
      st_next.rd_data = DBMRS_DW'({st_reg.pending, st_reg.bus_req,
                                   st_reg.fsm == DBMRS_XFER, st_reg.cur});
    end

    // Acknowledge follows the unit being run for an external requester
    for (int i = 0; i < DBMRS_NEXT; i++) begin
      st_next.ack[i] = (st_next.fsm == DBMRS_XFER) && (st_next.cur == 2'(i))
                       && (st_reg.ctrl[i].req_src == DBMRS_REQ_EXT);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg          <= '0;
      st_reg.pin_prev <= '1;
      st_reg.age      <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata        = st_reg.rd_data;
  assign bus_req          = st_reg.bus_req;
  assign transfer_ack_pin = st_reg.ack;
  assign xfer_busy        = st_reg.fsm == DBMRS_XFER;
  assign xfer_chan        = st_reg.cur;

endmodule : dbmrs_top

// File: dv/dbmrs_chk.sv
// Purpose : Port-level checks of bus ownership, acknowledge and read port
// Assumes : Bound onto dbmrs_top, one clock domain
// Notes   : Watches design ports only, inputs and outputs
module dbmrs_chk
  import dbmrs_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  sys_rst,
  input wire logic                  reg_rd,
  input wire logic [DBMRS_DW-1:0]   reg_rdata,
  input wire logic [DBMRS_NEXT-1:0] transfer_request_pin_n,
  input wire logic                  bus_grant,
  input wire logic                  bus_req,
  input wire logic [DBMRS_NEXT-1:0] transfer_ack_pin,
  input wire logic                  xfer_busy,
  input wire logic [1:0]            xfer_chan
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Ownership, handshake and read port
  // ----------------------------------------------------------------
  sequence s_unit_start;
    $rose(xfer_busy);
  endsequence
  sequence s_ack0_start;
    $rose(transfer_ack_pin[0]);
  endsequence
  busy_holds_bus_a: assert property (xfer_busy |-> bus_req)
    else $error("unit running without bus request");
  bus_drop_end_a: assert property ($fell(bus_req) |-> $fell(xfer_busy))
    else $error("bus request dropped apart from unit end");
  grant_first_a: assert property (s_unit_start |-> $past(bus_grant && bus_req))
    else $error("unit started without grant");
  req_then_unit_a: assert property ($rose(bus_req) |-> !xfer_busy)
    else $error("unit began with the bus request");
  req_age_a: assert property (s_ack0_start |-> $past(transfer_request_pin_n[0], 2) == 1'b0)
    else $error("acknowledge too soon after request");
  ack_ch0_a: assert property (transfer_ack_pin[0] |-> xfer_busy && xfer_chan == 2'h0)
    else $error("acknowledge 0 outside a channel 0 unit");
  ack_ch1_a: assert property (transfer_ack_pin[1] |-> xfer_busy && xfer_chan == 2'h1)
    else $error("acknowledge 1 outside a channel 1 unit");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
endmodule : dbmrs_chk

bind dbmrs_top dbmrs_chk i_chk (.clock, .sys_rst, .reg_rd, .reg_rdata, .transfer_request_pin_n,
  .bus_grant, .bus_req, .transfer_ack_pin, .xfer_busy, .xfer_chan);

// File: dv/dbmrs_arb.sv
// Purpose : Bus arbiter and external requester standing beside the block
// Assumes : Grant is a level that follows the bus request
// Notes   : Slow mode holds the grant back three states
module dbmrs_arb
  import dbmrs_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic                  bus_req,
  input  wire logic [DBMRS_NEXT-1:0] transfer_ack_pin,
  input  wire logic                  slow_grant,
  input  wire logic [DBMRS_NEXT-1:0] req_go,
  input  wire logic [DBMRS_NEXT-1:0] req_hold,
  output logic                       bus_grant,
  output logic      [DBMRS_NEXT-1:0] transfer_request_pin_n
);
  logic [1:0]            wait_reg;
  logic [DBMRS_NEXT-1:0] want_reg;
  logic [DBMRS_NEXT-1:0] ack_d_reg;
  // ----------------------------------------------------------------
  // Requester and arbiter
  // ----------------------------------------------------------------
  // Hold parks the line low, as an edge requester that never lets go
  assign transfer_request_pin_n = ~(want_reg | req_hold);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wait_reg  <= 2'h0;
      want_reg  <= 2'h0;
      ack_d_reg <= 2'h0;
      bus_grant <= 1'b0;
    end else begin
      wait_reg  <= bus_req ? wait_reg + {1'b0, wait_reg != 2'h3} : 2'h0;
      bus_grant <= bus_req && (!slow_grant || wait_reg == 2'h3);
      ack_d_reg <= transfer_ack_pin;
      // Drops at the first acknowledged state, before the next sample
      want_reg  <= req_go | (want_reg & ~(transfer_ack_pin & ~ack_d_reg));
    end
  end
endmodule : dbmrs_arb

// File: dv/testbench.sv
// Purpose : Directed regression of bus modes, pre-emption and request pins
// Assumes : dbmrs_top with the arbiter and requester model beside it
// Notes   : Unit order is logged from the programmed unit length
module testbench
  import dbmrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clock = 1'b0;
  logic                  sys_rst = 1'b1;
  logic [DBMRS_AW-1:0]   reg_addr = 8'h00;
  logic [DBMRS_DW-1:0]   reg_wdata = 32'h0, reg_rdata;
  logic                  reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0, busy_d = 1'b0;
  logic [DBMRS_NEXT-1:0] pin_n, ack, go = 2'h0, hold = 2'h0;
  logic [DBMRS_NCH-1:0]  periph_req = 4'h0;
  logic                  bus_grant, bus_req, xfer_busy, breq_d = 1'b0;
  logic [1:0]            xfer_chan, logq [$];
  logic [31:0]           bad_w [6] = '{32'h5, 32'h61b, 32'h41, 32'h19, 32'h481, 32'h29};
  logic [31:0]           bad_e [6] = '{32'h2004, 32'h261a, 32'h2040, 32'h2018, 32'h2480, 32'h2028};
  int                    n_mismatch, check_count, cyc, drops, busy_cyc, ack_len, pos, ulen;
  int                    n0, d0, b0, a0;
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end
  always #20 clock = ~clock;
  dbmrs_top i_dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .transfer_request_pin_n(pin_n), .periph_req, .bus_grant, .bus_req,
    .transfer_ack_pin(ack), .xfer_busy, .xfer_chan);
  dbmrs_arb i_arb (.clock, .sys_rst, .bus_req, .transfer_ack_pin(ack), .slow_grant(slow),
    .req_go(go), .req_hold(hold), .bus_grant, .transfer_request_pin_n(pin_n));
  // ----------------------------------------------------------------
  // Monitor, tasks and sequence
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cyc <= cyc + 1;
    busy_d <= xfer_busy;
    breq_d <= bus_req;
    if (breq_d && !bus_req) drops <= drops + 1;
    if (xfer_busy) busy_cyc <= busy_cyc + 1;
    if (ack[0]) ack_len <= ack_len + 1;
    // Unit boundary is inferred, so a wrong unit length shows as a wrong order
    if (xfer_busy && (!busy_d || pos == ulen - 1)) begin
      logq.push_back(xfer_chan);
      pos <= 0;
    end else if (xfer_busy) pos <= pos + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude;
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
    @(posedge clock);
  endtask : rd
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK(nm, e, v)
  endtask : rdc
  task automatic settle;
    int q;
    q = 0;
    while (q < 24) begin
      @(negedge clock);
      q = (bus_req || xfer_busy) ? 0 : q + 1;
    end
    @(posedge clock);
  endtask : settle
  task automatic snap;
    n0 = logq.size();
    d0 = drops;
    b0 = busy_cyc;
    a0 = ack_len;
  endtask : snap
  task automatic pulse(input logic [1:0] g);
    go <= g;
    @(posedge clock);
    go <= 2'h0;
    settle();
  endtask : pulse
  task automatic preempt(input logic [31:0] c2, input logic [1:0] e1, input logic [1:0] e2);
    int i;
    snap();
    wr(8'h1c, 32'h6);
    wr(8'h18, 32'h3);
    do @(negedge clock); while (xfer_busy !== 1'b1);
    @(posedge clock);
    wr(8'h14, 32'h2);
    wr(8'h10, c2);
    settle();
    i = n0;
    while (i < logq.size() && logq[i] != 2'h2) i++;
    `CHK("pre-empt point", n0 + 1, i)
    `CHK("unit after first", e1, logq[i+1])
    `CHK("unit after second", e2, logq[i+2])
    `CHK("bus tenures", 1, drops - d0)
  endtask : preempt
  initial begin
    logic [31:0] v;
    int i;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rdc("ctrl reset", 8'h00, 32'h0);
    rdc("count reset", 8'h04, 32'h0);
    rdc("status reset", 8'h44, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rdc("unmapped", 8'h80, 32'h0);
    wr(8'h40, 32'h23);
    rdc("wait", 8'h40, 32'h23);
    ulen = 8;
    snap();
    wr(8'h14, 32'h2);
    wr(8'h10, 32'h1);
    settle();
    `CHK("steal releases", 2, drops - d0)
    `CHK("dual unit states", 16, busy_cyc - b0)
    rdc("steal done", 8'h10, 32'h1000);
    slow <= 1'b1;
    snap();
    wr(8'h1c, 32'h3);
    wr(8'h18, 32'h3);
    settle();
    slow <= 1'b0;
    `CHK("burst tenures", 1, drops - d0)
    `CHK("burst states", 24, busy_cyc - b0)
    preempt(32'h1003, 2'h2, 2'h3);
    preempt(32'h1001, 2'h3, 2'h2);
    snap();
    wr(8'h1c, 32'h1);
    for (i = 0; i < 6; i++) begin
      wr(8'h18, bad_w[i] | 32'h1000);
      rdc("refused setup", 8'h18, bad_e[i]);
    end
    settle();
    `CHK("refused runs", 0, busy_cyc - b0)
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h1619);
    periph_req <= 4'h4;
    @(posedge clock);
    periph_req <= 4'h0;
    settle();
    rdc("serial steal", 8'h10, 32'h1618);
    snap();
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h45);
    pulse(2'h1);
    `CHK("single ack states", 3, ack_len - a0)
    rdc("single done", 8'h00, 32'h1044);
    wr(8'h04, 32'h5);
    wr(8'h00, 32'h1047);
    pulse(2'h1);
    rd(8'h04, v);
    `CHK("level burst stop", 32'h4, v)
    wr(8'h00, 32'h46);
    rdc("software stop", 8'h00, 32'h46);
    wr(8'h0c, 32'h3);
    wr(8'h08, 32'h145);
    hold <= 2'h2;
    settle();
    rdc("edge once", 8'h0c, 32'h2);
    hold <= 2'h0;
    @(posedge clock);
    pulse(2'h2);
    rdc("edge again", 8'h0c, 32'h1);
    conclude();
  end
endmodule : testbench
